//--- hdl/fcm_protect_unit.sv
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - four channels, each with one upper-bound and one lower-bound register
// - word address compared against upper bound field bits 15:0
// - word address compared against lower bound field bits 15:0
// - lower register bits 18:16 must equal address bits 20:18
// - address below lower bound is refused by the channel
// - address inside the window is judged by the control field settings
// - control holds four 4-bit fields, channel 3 highest
// - a control register write takes two clock cycles
// - read-only bit set makes writes a violation
// - privileged bit set makes user-mode access a violation
// - enable bit switches the channel on or off
// - checking happens only when some channel is active
// - peripheral mode makes channel active for top 2 MB addresses
// - otherwise the channel is active on its memory select
// - registers readable always, writable only privileged, reset to zero
// - reserved bits ignore writes
// - channel 0 enable at bit 1, peripheral bit at bit 0
module fcm_protect_unit
   import fcm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [3:0] hprot,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire fcm_access_t cpu_access,
   input wire logic [FCM_CHANNELS-1:0] mem_select,
   output logic access_violation,
   output logic [FCM_CHANNELS-1:0] channel_deny,
   output logic mem_write_enable
);

   // register map, one aligned word each, byte offsets below
   //   0x00 region 0 upper bound, bits 15:0
   //   0x04 region 0 lower bound, bits 15:0, equal field 18:16
   //   0x08 region 1 upper bound
   //   0x0c region 1 lower bound
   //   0x10 region 2 upper bound
   //   0x14 region 2 lower bound
   //   0x18 region 3 upper bound
   //   0x1c region 3 lower bound
   //   0x20 protect control, four fields of four bits
   //   0x24 sticky denial record, one bit per channel
   // anything with haddr above 0xff is taken but ignored
   // unused high bits read as zero and drop writes

   // bus side behaviour
   //   reads have a one-cycle data phase
   //   read data is loaded at the address phase edge
   //   a read right after a write sees the new value
   //   bound writes land at the end of their data phase
   //   a control write inserts one wait state
   //   control is loaded at the edge ending the second cycle
   //   user-mode and sub-word writes change nothing
   //   the response is always okay

   // check side behaviour
   //   fully combinational, answered in the access cycle
   //   word address is access address bits 17:2
   //   bounds are inclusive at both ends
   //   equal field must match address bits 20:18
   //   an active channel denies anything outside its window
   //   inside the window, read-only and privileged bits judge
   //   a disabled channel never denies
   //   peripheral mode ignores the memory select input
   //   with no channel active every access passes

   // hazards and limits
   //   software must pre-rotate bounds, hardware does not
   //   the denial record is set by any denying edge
   //   a new denial wins over a clear in the same cycle
   //   mem_write_enable drops in the cycle of a violation
   //   the abort path must sample violation in that cycle
   //   control changes only after its wait state, so a check
   //   in the wait cycle still uses the old settings

   // register offset decode used by the read and the write path
   function automatic logic is_upper(input logic [7:0] ofs, input int unsigned ch);
      logic [7:0] base;
      base = 8'(ch * 8);
      is_upper = (ofs == base);
   endfunction : is_upper

   function automatic logic is_lower(input logic [7:0] ofs, input int unsigned ch);
      logic [7:0] base;
      base = 8'(ch * 8 + 4);
      is_lower = (ofs == base);
   endfunction : is_lower

   // register state
   logic [FCM_BOUND_W-1:0] upper_r [FCM_CHANNELS];
   logic [FCM_BOUND_W-1:0] upper_nxt [FCM_CHANNELS];
   logic [FCM_LOWER_W-1:0] lower_r [FCM_CHANNELS];
   logic [FCM_LOWER_W-1:0] lower_nxt [FCM_CHANNELS];
   logic [FCM_CTRL_W-1:0] ctrl_r;
   logic [FCM_CTRL_W-1:0] ctrl_nxt;
   logic [FCM_CHANNELS-1:0] status_r;
   logic [FCM_CHANNELS-1:0] status_nxt;

   // bus data-phase state
   fcm_state_t state_r;
   fcm_state_t state_nxt;
   logic dp_valid_r;
   logic dp_valid_nxt;
   logic dp_write_r;
   logic dp_write_nxt;
   logic dp_privileged_only_flag_r;
   logic dp_privileged_only_flag_nxt;
   logic dp_word_r;
   logic dp_word_nxt;
   logic [7:0] dp_ofs_r;
   logic [7:0] dp_ofs_nxt;
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;

   logic ap_take;
   logic wr_ok;
   logic ctrl_wr_dp;
   logic commit_bound;
   logic commit_ctrl;
   logic [FCM_CHANNELS-1:0] chan_active;
   logic [FCM_CHANNELS-1:0] chan_deny;
   logic [FCM_CHANNELS-1:0] status_clr;

   // address phase accepted when selected, active and bus ready
   assign ap_take = hsel & htrans[1] & hready;

   // only privileged whole-word writes change anything
   assign wr_ok = dp_valid_r & dp_write_r & dp_privileged_only_flag_r & dp_word_r;

   // a control write stretches its data phase to two cycles
   assign ctrl_wr_dp = wr_ok & (dp_ofs_r == FCM_OFS_CTRL);
   assign commit_ctrl = ctrl_wr_dp & (state_r == FCM_ST_CTRL_WAIT);
   assign commit_bound = wr_ok & (dp_ofs_r != FCM_OFS_CTRL);

   assign hreadyout = ~(ctrl_wr_dp & (state_r == FCM_ST_IDLE));
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // data-phase capture and wait state sequencing
   always_comb begin
      dp_valid_nxt = dp_valid_r;
      dp_write_nxt = dp_write_r;
      dp_privileged_only_flag_nxt = dp_privileged_only_flag_r;
      dp_word_nxt = dp_word_r;
      dp_ofs_nxt = dp_ofs_r;
      state_nxt = state_r;
      unique case (state_r)
         FCM_ST_IDLE: begin
            if (ctrl_wr_dp) begin
               state_nxt = FCM_ST_CTRL_WAIT;
            end
         end
         FCM_ST_CTRL_WAIT: begin
            state_nxt = FCM_ST_IDLE;
         end
         default: begin
            state_nxt = FCM_ST_IDLE;
         end
      endcase
      if (hreadyout) begin
         dp_valid_nxt = ap_take;
         dp_write_nxt = hwrite;
         dp_privileged_only_flag_nxt = hprot[1];
         dp_word_nxt = (hsize == FCM_HSIZE_WORD);
         dp_ofs_nxt = haddr[7:0];
         if (haddr[31:8] != 24'h000000) begin
            dp_valid_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= FCM_ST_IDLE;
         dp_valid_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_privileged_only_flag_r <= 1'b0;
         dp_word_r <= 1'b0;
         dp_ofs_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         dp_valid_r <= dp_valid_nxt;
         dp_write_r <= dp_write_nxt;
         dp_privileged_only_flag_r <= dp_privileged_only_flag_nxt;
         dp_word_r <= dp_word_nxt;
         dp_ofs_r <= dp_ofs_nxt;
      end
   end

   // bound and control register updates
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (commit_ctrl) begin
         ctrl_nxt = hwdata[FCM_CTRL_W-1:0];
      end
      for (int i = 0; i < FCM_CHANNELS; i++) begin
         upper_nxt[i] = upper_r[i];
         lower_nxt[i] = lower_r[i];
         if (commit_bound && is_upper(dp_ofs_r, i)) begin
            upper_nxt[i] = hwdata[FCM_BOUND_W-1:0];
         end
         if (commit_bound && is_lower(dp_ofs_r, i)) begin
            lower_nxt[i] = hwdata[FCM_LOWER_W-1:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= FCM_CTRL_RST;
         for (int i = 0; i < FCM_CHANNELS; i++) begin
            upper_r[i] <= FCM_UPPER_RST;
            lower_r[i] <= FCM_LOWER_RST;
         end
      end else begin
         ctrl_r <= ctrl_nxt;
         for (int i = 0; i < FCM_CHANNELS; i++) begin
            upper_r[i] <= upper_nxt[i];
            lower_r[i] <= lower_nxt[i];
         end
      end
   end

   // sticky denial record, write one to clear, a new denial wins
   always_comb begin
      status_clr = '0;
      if (commit_bound && dp_ofs_r == FCM_OFS_STATUS) begin
         status_clr = hwdata[FCM_CHANNELS-1:0];
      end
      status_nxt = (status_r & ~status_clr) | chan_deny;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_r <= '0;
      end else begin
         status_r <= status_nxt;
      end
   end

   // read data taken at the address phase, from the values about to stand
   always_comb begin
      hrdata_nxt = hrdata_r;
      if (ap_take && !hwrite) begin
         hrdata_nxt = 32'h00000000;
         if (haddr[31:8] == 24'h000000) begin
            if (haddr[7:0] == FCM_OFS_CTRL) begin
               hrdata_nxt = {16'h0000, ctrl_nxt};
            end
            if (haddr[7:0] == FCM_OFS_STATUS) begin
               hrdata_nxt = {28'h0000000, status_nxt};
            end
            for (int i = 0; i < FCM_CHANNELS; i++) begin
               if (is_upper(haddr[7:0], i)) begin
                  hrdata_nxt = {16'h0000, upper_nxt[i]};
               end
               if (is_lower(haddr[7:0], i)) begin
                  hrdata_nxt = {13'h0000, lower_nxt[i]};
               end
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h00000000;
      end else begin
         hrdata_r <= hrdata_nxt;
      end
   end

   // per-channel activity and judgement of the access
   for (genvar g = 0; g < FCM_CHANNELS; g++) begin : g_chan
      fcm_chan_ctrl_t cfg;
      logic [11:0] top;
      logic [FCM_BOUND_W-1:0] word;
      logic [FCM_EQUAL_W-1:0] eq;
      logic below;
      logic above;
      logic eq_hit;
      logic in_window;
      logic rights_bad;

      assign cfg = ctrl_r[g*FCM_CTRL_FIELD_W +: FCM_CTRL_FIELD_W];
      assign top = cpu_access.addr[31:FCM_ADDR_TOP_LSB];
      assign word = cpu_access.addr[FCM_ADDR_WORD_LSB +: FCM_BOUND_W];
      assign eq = cpu_access.addr[FCM_ADDR_EQUAL_LSB +: FCM_EQUAL_W];

      // channel active in peripheral range or on its memory select
      always_comb begin
         chan_active[g] = 1'b0;
         if (cfg.enable) begin
            if (cfg.periph_range) begin
               chan_active[g] = (top == FCM_PERIPH_TOP) | (top == FCM_PERIPH_NEXT);
            end else begin
               chan_active[g] = mem_select[g];
            end
         end
      end

      assign below = word < lower_r[g][FCM_BOUND_W-1:0];
      assign above = word > upper_r[g];
      assign eq_hit = eq == lower_r[g][FCM_LOWER_W-1:FCM_BOUND_W];
      assign in_window = ~below & ~above & eq_hit;

      // read-only and privileged-only restrictions
      assign rights_bad = (cfg.read_only_flag & cpu_access.write)
         | (cfg.privileged_only_flag & ~cpu_access.privileged);

      assign chan_deny[g] = cpu_access.valid & chan_active[g]
         & (~in_window | rights_bad);
   end

   // unchecked unless a channel is active; block the write on a violation
   assign access_violation = |chan_deny;
   assign channel_deny = chan_deny;
   assign mem_write_enable = cpu_access.valid & cpu_access.write & ~access_violation;

endmodule : fcm_protect_unit

//--- hdl/fcm_pkg.sv
package fcm_pkg;

   // channel count and register map
   localparam int unsigned FCM_CHANNELS = 4;
   localparam logic [7:0] FCM_OFS_UPPER0 = 8'h00;
   localparam logic [7:0] FCM_OFS_LOWER0 = 8'h04;
   localparam logic [7:0] FCM_OFS_UPPER1 = 8'h08;
   localparam logic [7:0] FCM_OFS_LOWER1 = 8'h0c;
   localparam logic [7:0] FCM_OFS_UPPER2 = 8'h10;
   localparam logic [7:0] FCM_OFS_LOWER2 = 8'h14;
   localparam logic [7:0] FCM_OFS_UPPER3 = 8'h18;
   localparam logic [7:0] FCM_OFS_LOWER3 = 8'h1c;
   localparam logic [7:0] FCM_OFS_CTRL = 8'h20;
   localparam logic [7:0] FCM_OFS_STATUS = 8'h24;

   // field layout
   localparam int unsigned FCM_BOUND_W = 16;
   localparam int unsigned FCM_EQUAL_W = 3;
   localparam int unsigned FCM_LOWER_W = FCM_BOUND_W + FCM_EQUAL_W;
   localparam int unsigned FCM_CTRL_FIELD_W = 4;
   localparam int unsigned FCM_CTRL_W = FCM_CHANNELS * FCM_CTRL_FIELD_W;
   localparam int unsigned FCM_ADDR_WORD_LSB = 2;
   localparam int unsigned FCM_ADDR_EQUAL_LSB = 18;
   localparam int unsigned FCM_ADDR_TOP_LSB = 20;
   localparam logic [11:0] FCM_PERIPH_TOP = 12'hfff;
   localparam logic [11:0] FCM_PERIPH_NEXT = 12'hffe;

   // values after reset
   localparam logic [FCM_BOUND_W-1:0] FCM_UPPER_RST = 16'h0000;
   localparam logic [FCM_LOWER_W-1:0] FCM_LOWER_RST = 19'h00000;
   localparam logic [FCM_CTRL_W-1:0] FCM_CTRL_RST = 16'h0000;

   // cycles a control write occupies on the bus
   localparam int unsigned FCM_CTRL_WRITE_CYCLES = 2;

   // ahb codes
   localparam logic [2:0] FCM_HSIZE_WORD = 3'h2;

   // one control field, high bit first
   typedef struct packed {
      logic read_only_flag;
      logic privileged_only_flag;
      logic enable;
      logic periph_range;
   } fcm_chan_ctrl_t;

   // one processor access under check
   typedef struct packed {
      logic [31:0] addr;
      logic valid;
      logic write;
      logic privileged;
   } fcm_access_t;

   typedef enum logic [1:0] {
      FCM_ST_IDLE = 2'b01,
      FCM_ST_CTRL_WAIT = 2'b10
   } fcm_state_t;

endpackage : fcm_pkg

//--- testbench/fcm_cpu_model.sv
`timescale 1ns/1ps
// processor bus and decoder: one access per request, idle bus inverts the last address
module fcm_cpu_model
   import fcm_pkg::*;
(
   input wire logic hclk,
   input wire logic go,
   input wire fcm_access_t req,
   input wire logic [FCM_CHANNELS-1:0] sel,
   output fcm_access_t cpu_access,
   output logic [FCM_CHANNELS-1:0] mem_select
);
   fcm_access_t q = '0;
   logic [FCM_CHANNELS-1:0] s = '0;
   // present the request for one cycle after the edge that takes it
   always @(posedge hclk) begin
      q <= go ? req : '{addr: ~q.addr, default: 1'b0};
      s <= go ? sel : '0;
   end
   assign cpu_access = q;
   assign mem_select = s;
endmodule : fcm_cpu_model

//--- testbench/fcm_protect_unit_checker.sv
`timescale 1ns/1ps
// bus answer timing and check path relations
module fcm_protect_unit_checker
   import fcm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [3:0] hprot,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire fcm_access_t cpu_access,
   input wire logic [FCM_CHANNELS-1:0] mem_select,
   input wire logic access_violation,
   input wire logic [FCM_CHANNELS-1:0] channel_deny,
   input wire logic mem_write_enable
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // taken transfer, privileged word write, control write, top 2 MB address
   wire logic tk = hsel & htrans[1] & hready;
   wire logic pw = tk & hwrite & hprot[1] & (hsize == FCM_HSIZE_WORD);
   wire logic cw = pw & (haddr == 32'h20);
   wire logic top = (cpu_access.addr[31:20] == FCM_PERIPH_TOP) |
      (cpu_access.addr[31:20] == FCM_PERIPH_NEXT);
   property p_ctrl_wait; cw |=> !hreadyout ##1 hreadyout; endproperty
   a_ctrl_wait: assert property (p_ctrl_wait) else $error("control write wait");
   property p_wait_cause; !hreadyout |-> $past(cw); endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("stray wait state");
   property p_bound_fast; pw && haddr < 32'h20 |=> hreadyout; endproperty
   a_bound_fast: assert property (p_bound_fast) else $error("bound write waited");
   property p_user_fast; tk && hwrite && !hprot[1] |=> hreadyout; endproperty
   a_user_fast: assert property (p_user_fast) else $error("user write waited");
   property p_rdata_hold; !$past(tk && !hwrite) |-> $stable(hrdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_wen; mem_write_enable == (cpu_access.valid & cpu_access.write & !access_violation);
   endproperty
   a_wen: assert property (p_wen) else $error("write not suppressed");
   property p_viol; access_violation == (cpu_access.valid && channel_deny != 4'h0); endproperty
   a_viol: assert property (p_viol) else $error("violation mismatch");
   property p_active; (channel_deny & ~(mem_select | {4{top}})) == 4'h0; endproperty
   a_active: assert property (p_active) else $error("inactive channel denied");
   c_ctrl: cover property (cw);
   c_viol: cover property (access_violation);
   c_read: cover property (tk && !hwrite);
endmodule : fcm_protect_unit_checker
bind fcm_protect_unit fcm_protect_unit_checker fcm_protect_unit_checker_inst (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hprot(hprot), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .cpu_access(cpu_access), .mem_select(mem_select), .access_violation(access_violation),
   .channel_deny(channel_deny), .mem_write_enable(mem_write_enable));

//--- testbench/fcm_protect_unit_tb.sv
`timescale 1ns/1ps
module fcm_protect_unit_tb
   import fcm_pkg::*;
;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = '0;
   logic [3:0] hprot = '0, sel = '0, mem_select, channel_deny;
   logic hreadyout, access_violation, mem_write_enable;
   fcm_access_t req = '0, cpu_access;
   int failures = 0, n_tests = 0, cyc = 0;
   fcm_protect_unit fcm_protect_unit_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
      .hrdata(hrdata), .cpu_access(cpu_access), .mem_select(mem_select),
      .access_violation(access_violation), .channel_deny(channel_deny),
      .mem_write_enable(mem_write_enable));
   fcm_cpu_model fcm_cpu_model_inst (.hclk(hclk), .go(go), .req(req), .sel(sel),
      .cpu_access(cpu_access), .mem_select(mem_select));
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one single transfer, entered just after an edge; read data lands in r
   task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d,
      input logic p, input logic [2:0] sz);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      hprot <= {2'b00, p, 1'b1};
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      @(posedge hclk);
   endtask : ahb
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      ahb(a, 1'b1, d, 1'b1, FCM_HSIZE_WORD);
   endtask : wr
   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      ahb(a, 1'b0, 32'h0, 1'b1, FCM_HSIZE_WORD);
      check(r, e);
   endtask : rdc
   // one checked processor access; deny pattern and write enable judged
   task automatic acc(input logic [31:0] a, input logic w, input logic p,
      input logic [3:0] s, input logic [3:0] e);
      go <= 1'b1;
      req <= '{addr: a, valid: 1'b1, write: w, privileged: p};
      sel <= s;
      @(posedge hclk);
      go <= 1'b0;
      @(negedge hclk);
      check({28'h0, channel_deny}, {28'h0, e});
      check({31'h0, mem_write_enable}, {31'h0, w & (e == 4'h0)});
      @(posedge hclk);
   endtask : acc
   task automatic t_regs();
      for (int i = 0; i < 10; i++) rdc(32'(4 * i), 32'h0);
      rdc(32'h100, 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr(32'(4 * i), 32'hffffffff);
         rdc(32'(4 * i), i[0] ? 32'h0007ffff : 32'h0000ffff);
      end
      wr(32'h20, 32'hffffffff);
      rdc(32'h20, 32'h0000ffff);
      ahb(32'h0, 1'b1, 32'h0, 1'b0, FCM_HSIZE_WORD);
      rdc(32'h0, 32'h0000ffff);
      ahb(32'h0, 1'b1, 32'h0, 1'b1, 3'h0);
      rdc(32'h0, 32'h0000ffff);
      for (int i = 0; i < 4; i++) begin
         wr(32'(8 * i), 32'h200);
         wr(32'(8 * i + 4), 32'h10100);
      end
      wr(32'h20, 32'h0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_check();
      logic [31:0] ad [5] = '{32'h403fc, 32'h40400, 32'h40800, 32'h40804, 32'h80540};
      logic [3:0] dn [5] = '{4'h1, 4'h0, 4'h0, 4'h1, 4'h1};
      acc(32'h403fc, 1'b1, 1'b1, 4'hf, 4'h0);
      wr(32'h20, 32'h2);
      for (int i = 0; i < 5; i++) acc(ad[i], 1'b1, 1'b1, 4'h1, dn[i]);
      acc(32'h403fc, 1'b1, 1'b1, 4'h0, 4'h0);
      wr(32'h20, 32'ha);
      acc(32'h40400, 1'b1, 1'b1, 4'h1, 4'h1);
      acc(32'h40400, 1'b0, 1'b1, 4'h1, 4'h0);
      wr(32'h20, 32'h6);
      acc(32'h40400, 1'b0, 1'b0, 4'h1, 4'h1);
      acc(32'h40400, 1'b0, 1'b1, 4'h1, 4'h0);
      for (int c = 1; c < 4; c++) begin
         wr(32'h20, 32'ha << (4 * c));
         acc(32'h40400, 1'b1, 1'b1, 4'hf, 4'(1 << c));
      end
      wr(32'h20, 32'hb);
      acc(32'hfff00000, 1'b1, 1'b1, 4'h0, 4'h1);
      acc(32'hffe00000, 1'b0, 1'b0, 4'h0, 4'h1);
      acc(32'hffd00000, 1'b1, 1'b1, 4'h1, 4'h0);
      $display("test check done");
   endtask : t_check
   // reset in mid-run clears the programmed registers
   task automatic t_reset();
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(32'h20, 32'h0);
      rdc(32'h4, 32'h0);
      $display("test reset done");
   endtask : t_reset
   initial begin
      forever #50 hclk = ~hclk;
   end
   // cut a hang short
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_check();
      t_reset();
      final_report();
   end
endmodule : fcm_protect_unit_tb
